// file: core/exp_trig_pkg.sv
// constants, register map and types for the external trigger exposure controller
package exp_trig_pkg;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SHUTTER = 8'h04;
    localparam logic [7:0] OFS_CAPTURE = 8'h08;
    localparam logic [7:0] OFS_READOUT = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // ==========================================================
    // field positions
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_POL_BIT = 1;
    localparam int CTRL_MODE_BIT = 2;
    localparam int CTRL_SEL_LSB = 4;
    localparam int CAP_SINGLE_BIT = 0;
    localparam int CAP_REPEAT_BIT = 1;
    localparam int ST_EXPOSING_BIT = 0;
    localparam int ST_READING_BIT = 1;
    localparam int ST_SENDING_BIT = 2;
    localparam int ST_READY_BIT = 3;
    localparam int ST_COUNT_LSB = 16;

    // ==========================================================
    // widths and reset values
    localparam int CNT_W = 24;
    localparam int FRAME_W = 16;
    localparam int NPORT = 4;
    localparam logic [CNT_W-1:0] SHUTTER_RST = 24'h0003e8;
    localparam logic [CNT_W-1:0] READOUT_RST = 24'h0007d0;
    localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
    localparam logic [1:0] SEL_RST = 2'h0;
    localparam logic POL_FALLING = 1'b0;
    localparam logic POL_RISING = 1'b1;
    localparam logic MODE_PROG = 1'b0;
    localparam logic MODE_LEVEL = 1'b1;

    // ==========================================================
    // types
    typedef struct packed {
        logic on;
        logic pol;
        logic mode;
        logic [1:0] sel;
    } trig_cfg_t;

    localparam trig_cfg_t CFG_RST = '{on: 1'b0, pol: POL_RISING, mode: MODE_PROG, sel: SEL_RST};

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PROG = 3'b010,
        ST_LEVEL = 3'b100
    } exp_state_t;

endpackage : exp_trig_pkg

// file: core/exp_trig_ctrl.sv
// external trigger exposure controller with apb register slave
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

module exp_trig_ctrl
    import exp_trig_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NPORT-1:0] ext_exposure_start_in,
    input wire logic image_sent,
    output logic exposure_active,
    output logic exposure_ready_out,
    output logic readout_start,
    output logic readout_busy
);

    // ==========================================================
    // helpers
    function automatic logic at_level(input logic pin, input logic pol);
        at_level = (pol == POL_RISING) ? pin : ~pin;
    endfunction : at_level

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // ==========================================================
    // declarations
    trig_cfg_t soft_cfg_r;
    trig_cfg_t act_cfg_r;
    logic [CNT_W-1:0] shutter_r;
    logic [CNT_W-1:0] readout_len_r;
    logic single_r;
    logic repeat_r;
    logic single_used_r;
    logic [NPORT-1:0] sync1_r;
    logic [NPORT-1:0] sync2_r;
    logic [NPORT-1:0] sync3_r;
    logic [NPORT-1:0] filt_r;
    logic [NPORT-1:0] prev_r;
    exp_state_t state_r;
    exp_state_t state_nxt;
    logic [CNT_W-1:0] exp_cnt_r;
    logic [CNT_W-1:0] rd_cnt_r;
    logic sending_r;
    logic [FRAME_W-1:0] frame_cnt_r;
    logic ready_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic ro_start_r;
    logic expo_r;
    logic rd_busy_r;

    logic lvl_now;
    logic lvl_prev;
    logic act_edge;
    logic armed;
    logic start_w;
    logic min_done;
    logic end_w;
    logic wr_acc;
    logic rd_setup;
    logic mapped;
    logic ready_nxt;

    // ==========================================================
    // apb slave: one wait state, answer registered
    assign wr_acc = psel & penable & pwrite & pready_r;
    assign rd_setup = psel & penable & ~pready_r;
    assign mapped = hit(paddr, OFS_CTRL) | hit(paddr, OFS_SHUTTER) | hit(paddr, OFS_CAPTURE)
        | hit(paddr, OFS_READOUT) | hit(paddr, OFS_STATUS);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= rd_setup;
            pslverr_r <= rd_setup & ~mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
        end else if (rd_setup) begin
            prdata_r <= 32'h00000000;
            case (paddr)
                OFS_CTRL: begin
                    prdata_r[CTRL_ON_BIT] <= soft_cfg_r.on;
                    prdata_r[CTRL_POL_BIT] <= soft_cfg_r.pol;
                    prdata_r[CTRL_MODE_BIT] <= soft_cfg_r.mode;
                    prdata_r[CTRL_SEL_LSB +: 2] <= soft_cfg_r.sel;
                end
                OFS_SHUTTER: prdata_r[CNT_W-1:0] <= shutter_r;
                OFS_CAPTURE: begin
                    prdata_r[CAP_SINGLE_BIT] <= single_r;
                    prdata_r[CAP_REPEAT_BIT] <= repeat_r;
                end
                OFS_READOUT: prdata_r[CNT_W-1:0] <= readout_len_r;
                OFS_STATUS: begin
                    prdata_r[ST_EXPOSING_BIT] <= expo_r;
                    prdata_r[ST_READING_BIT] <= rd_busy_r;
                    prdata_r[ST_SENDING_BIT] <= sending_r;
                    prdata_r[ST_READY_BIT] <= ready_r;
                    prdata_r[ST_COUNT_LSB +: FRAME_W] <= frame_cnt_r;
                end
                default: prdata_r <= 32'h00000000;
            endcase
        end
    end

    // ==========================================================
    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_cfg_r <= CFG_RST;
            shutter_r <= SHUTTER_RST;
            readout_len_r <= READOUT_RST;
        end else if (wr_acc && mapped && !pslverr_r) begin
            if (hit(paddr, OFS_CTRL)) begin
                soft_cfg_r.on <= pwdata[CTRL_ON_BIT];
                soft_cfg_r.pol <= pwdata[CTRL_POL_BIT];
                soft_cfg_r.mode <= pwdata[CTRL_MODE_BIT];
                soft_cfg_r.sel <= pwdata[CTRL_SEL_LSB +: 2];
            end
            if (hit(paddr, OFS_SHUTTER)) begin
                shutter_r <= pwdata[CNT_W-1:0];
            end
            if (hit(paddr, OFS_READOUT)) begin
                readout_len_r <= pwdata[CNT_W-1:0];
            end
        end
    end

    // shadow copy so an exposure in flight never sees a new mode or port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_cfg_r <= CFG_RST;
        end else if (state_r == ST_IDLE && !start_w) begin
            act_cfg_r <= soft_cfg_r;
        end
    end

    // ==========================================================
    // capture arming; hardware clear loses to a software set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            single_r <= 1'b0;
            repeat_r <= 1'b0;
        end else begin
            if (wr_acc && hit(paddr, OFS_CAPTURE) && pwdata[CAP_SINGLE_BIT]) begin
                single_r <= 1'b1;
            end else if (image_sent && single_used_r) begin
                single_r <= 1'b0;
            end
            if (wr_acc && hit(paddr, OFS_CAPTURE)) begin
                repeat_r <= pwdata[CAP_REPEAT_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            single_used_r <= 1'b0;
        end else if (start_w && single_r && !repeat_r) begin
            single_used_r <= 1'b1;
        end else if (image_sent || !single_r) begin
            single_used_r <= 1'b0;
        end
    end

    // ==========================================================
    // input synchroniser and filter: a level counts once stages 2 and 3 agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
            filt_r <= '0;
            prev_r <= '0;
        end else begin
            sync1_r <= ext_exposure_start_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            for (int i = 0; i < NPORT; i++) begin
                if (sync2_r[i] == sync3_r[i]) begin
                    filt_r[i] <= sync3_r[i];
                end
            end
            prev_r <= filt_r;
        end
    end

    assign lvl_now = at_level(filt_r[act_cfg_r.sel], act_cfg_r.pol);
    assign lvl_prev = at_level(prev_r[act_cfg_r.sel], act_cfg_r.pol);
    assign act_edge = lvl_now & ~lvl_prev;
    assign armed = repeat_r | (single_r & ~single_used_r);
    // edges while not ready or disabled simply fall away
    assign start_w = act_cfg_r.on & ready_r & act_edge & armed & (state_r == ST_IDLE);
    assign min_done = (exp_cnt_r + CNT_ONE) >= shutter_r;

    // ==========================================================
    // exposure state machine
    always_comb begin
        state_nxt = state_r;
        end_w = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (start_w) begin
                    state_nxt = (act_cfg_r.mode == MODE_LEVEL) ? ST_LEVEL : ST_PROG;
                end
            end
            ST_PROG: begin
                if (min_done) begin
                    end_w = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            ST_LEVEL: begin
                if (min_done && !lvl_now) begin
                    end_w = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            exp_cnt_r <= '0;
            expo_r <= 1'b0;
            frame_cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            expo_r <= (state_nxt != ST_IDLE);
            if (start_w) begin
                exp_cnt_r <= '0;
                frame_cnt_r <= frame_cnt_r + 1'b1;
            end else if (state_r != ST_IDLE && !min_done) begin
                exp_cnt_r <= exp_cnt_r + CNT_ONE;
            end
        end
    end

    // ==========================================================
    // readout and transmission tracking; runs beside a new exposure
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_cnt_r <= '0;
            rd_busy_r <= 1'b0;
            ro_start_r <= 1'b0;
            sending_r <= 1'b0;
        end else begin
            ro_start_r <= end_w;
            if (end_w) begin
                rd_cnt_r <= readout_len_r;
                rd_busy_r <= 1'b1;
            end else if (rd_busy_r) begin
                if (rd_cnt_r <= CNT_ONE) begin
                    rd_busy_r <= 1'b0;
                    rd_cnt_r <= '0;
                end else begin
                    rd_cnt_r <= rd_cnt_r - CNT_ONE;
                end
            end
            if (rd_busy_r && rd_cnt_r <= CNT_ONE) begin
                sending_r <= 1'b1;
            end else if (image_sent) begin
                sending_r <= 1'b0;
            end
        end
    end

    // ready only while idle and the next minimum exposure outlasts readout left
    assign ready_nxt = act_cfg_r.on && (state_nxt == ST_IDLE) && !end_w
        && (rd_cnt_r <= shutter_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_r <= 1'b0;
        end else begin
            ready_r <= ready_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign exposure_active = expo_r;
    assign exposure_ready_out = ready_r;
    assign readout_start = ro_start_r;
    assign readout_busy = rd_busy_r;

    // ==========================================================
    // assertions
    sequence s_start;
        (state_r == ST_IDLE) && start_w;
    endsequence

    sequence s_end;
        (state_r != ST_IDLE) && end_w;
    endsequence

    property p_off_no_start;
        @(posedge pclk) disable iff (!presetn)
        (!act_cfg_r.on && state_r == ST_IDLE) |=> (state_r == ST_IDLE);
    endproperty
    a_off_no_start: assert property (p_off_no_start) else $error("start while disabled");

    property p_ready_drop;
        @(posedge pclk) disable iff (!presetn)
        s_start |=> (!ready_r && expo_r);
    endproperty
    a_ready_drop: assert property (p_ready_drop) else $error("ready high at start");

    property p_ignore_not_ready;
        @(posedge pclk) disable iff (!presetn)
        (!ready_r && state_r == ST_IDLE) |=> (state_r == ST_IDLE);
    endproperty
    a_ignore_not_ready: assert property (p_ignore_not_ready) else $error("start not ready");

    property p_prog_len;
        @(posedge pclk) disable iff (!presetn)
        (s_end and (state_r == ST_PROG)) |-> ((exp_cnt_r + CNT_ONE) == shutter_r || shutter_r <= CNT_ONE);
    endproperty
    a_prog_len: assert property (p_prog_len) else $error("programmable length wrong");

    property p_level_end;
        @(posedge pclk) disable iff (!presetn)
        (s_end and (state_r == ST_LEVEL)) |-> (!lvl_now && min_done);
    endproperty
    a_level_end: assert property (p_level_end) else $error("level exposure ended early");

    property p_level_hold;
        @(posedge pclk) disable iff (!presetn)
        (state_r == ST_LEVEL && lvl_now) |=> (state_r == ST_LEVEL);
    endproperty
    a_level_hold: assert property (p_level_hold) else $error("level exposure cut short");

    property p_readout;
        @(posedge pclk) disable iff (!presetn)
        s_end |=> (ro_start_r && rd_busy_r && !expo_r);
    endproperty
    a_readout: assert property (p_readout) else $error("readout did not follow");

    property p_single_clear;
        @(posedge pclk) disable iff (!presetn)
        (image_sent && single_used_r && !wr_acc) |=> !single_r;
    endproperty
    a_single_clear: assert property (p_single_clear) else $error("single not cleared");

    property p_cfg_stable;
        @(posedge pclk) disable iff (!presetn)
        (state_r != ST_IDLE) |=> $stable(act_cfg_r);
    endproperty
    a_cfg_stable: assert property (p_cfg_stable) else $error("config changed mid exposure");

    property p_sync_delay;
        @(posedge pclk) disable iff (!presetn)
        $rose(sync3_r[0]) ##1 sync3_r[0] |-> filt_r[0];
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("filter missed level");

endmodule : exp_trig_ctrl

// file: tb/trig_source_model.sv
// behavioural external trigger source that watches the ready output
`timescale 1ns/1ps
module trig_source_model (
    input wire logic pclk,
    input wire logic go,
    input wire logic ignore_ready,
    input wire logic [1:0] port,
    input wire logic pol,
    input wire logic [15:0] hold,
    input wire logic ready,
    output logic [3:0] pins,
    output logic busy
);
    // ==========================================================
    // edge generator
    initial begin
        pins = 4'h0;
        busy = 1'b0;
        forever begin
            @(posedge pclk);
            if (!busy) begin
                pins <= {4{~pol}};
            end
            if (go) begin
                busy <= 1'b1;
                // ignore_ready only when a scenario wants an edge to be refused
                while (!ignore_ready && ready !== 1'b1) begin
                    @(negedge pclk);
                end
                @(posedge pclk);
                pins[port] <= pol;
                repeat (hold) @(posedge pclk);
                pins[port] <= ~pol;
                busy <= 1'b0;
            end
        end
    end
endmodule : trig_source_model

// file: tb/external_trigger_exposure_ctrl_tb_top.sv
// self-checking bench for the external trigger exposure controller
`timescale 1ns/1ps
module external_trigger_exposure_ctrl_tb_top import exp_trig_pkg::*;;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, exposure_active, exposure_ready_out, readout_start, readout_busy;
    logic [3:0] pins;
    logic image_sent = 1'b0, rb_q = 1'b0, go = 1'b0, ign = 1'b0, spol = 1'b1, sbusy;
    logic [1:0] sport = 2'h0;
    logic [15:0] shold = 16'h001e;
    int n_mismatch = 0;
    int n_compared = 0;

    always #20 pclk = ~pclk;
    // transmission engine stand-in: image counts as sent just after readout ends
    always @(posedge pclk) begin
        rb_q <= readout_busy;
        image_sent <= (rb_q === 1'b1) && (readout_busy === 1'b0);
    end

    exp_trig_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_exposure_start_in(pins), .image_sent(image_sent),
        .exposure_active(exposure_active), .exposure_ready_out(exposure_ready_out),
        .readout_start(readout_start), .readout_busy(readout_busy));
    trig_source_model i_src (.pclk(pclk), .go(go), .ignore_ready(ign), .port(sport),
        .pol(spol), .hold(shold), .ready(exposure_ready_out), .pins(pins), .busy(sbusy));

    // ==========================================================
    // common tasks
    task summarize;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize

    task chk(input bit ok, input string msg);
        n_compared++;
        if (!ok) begin
            n_mismatch++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk

    // pready, prdata and pslverr are taken at the rising edge that samples pready high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        logic ok;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        ok = 1'b0;
        while (!ok && n < 20) begin
            @(posedge pclk);
            ok = (pready === 1'b1);
            rd = prdata;
            err = pslverr;
            n++;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (!ok) begin
            n_mismatch++;
            summarize();
        end
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        logic err;
        apb(1'b0, a, 32'h0, v, err);
    endtask : rd

    task automatic cfg(input logic on, input logic pol, input logic mode, input logic [1:0] sel);
        logic [31:0] d;
        d = 32'h0;
        d[CTRL_ON_BIT] = on;
        d[CTRL_POL_BIT] = pol;
        d[CTRL_MODE_BIT] = mode;
        d[CTRL_SEL_LSB +: 2] = sel;
        wr(OFS_CTRL, d);
        spol <= pol;
        repeat (8) @(posedge pclk);
    endtask : cfg

    task fire(input logic [1:0] p, input logic [15:0] h, input logic i);
        sport <= p;
        shold <= h;
        ign <= i;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        @(posedge pclk);
    endtask : fire

    // length of the next exposure in cycles, -1 if none starts within win
    task automatic expo(input int win, output int len, output logic rs_ok);
        int n;
        n = 0;
        len = 0;
        rs_ok = 1'b0;
        while (exposure_active !== 1'b1 && n < win) begin
            @(negedge pclk);
            n++;
        end
        if (exposure_active === 1'b1) begin
            while (exposure_active === 1'b1 && len < 5000) begin
                len++;
                @(negedge pclk);
            end
            rs_ok = (readout_start === 1'b1) && (readout_busy === 1'b1);
        end else begin
            len = -1;
        end
        @(posedge pclk);
    endtask : expo

    task automatic settle;
        int n;
        n = 0;
        while ((sbusy !== 1'b0 || readout_busy !== 1'b0 || exposure_active !== 1'b0) && n < 3000) begin
            @(negedge pclk);
            n++;
        end
        if (n >= 3000) begin
            n_mismatch++;
            summarize();
        end
        repeat (6) @(posedge pclk);
    endtask : settle

    // ==========================================================
    // scenarios
    task automatic t_reset;
        logic [31:0] v;
        logic err;
        rd(OFS_CTRL, v);
        chk(v[CTRL_ON_BIT] === 1'b0 && v[CTRL_POL_BIT] === POL_RISING && v[CTRL_MODE_BIT] === MODE_PROG
            && v[CTRL_SEL_LSB +: 2] === SEL_RST && v[31:6] === 26'h0, "ctrl reset value");
        rd(OFS_SHUTTER, v);
        chk(v === {8'h00, SHUTTER_RST}, "shutter reset value");
        rd(OFS_READOUT, v);
        chk(v === {8'h00, READOUT_RST}, "readout reset value");
        rd(OFS_CAPTURE, v);
        chk(v === 32'h0, "capture reset value");
        chk(exposure_ready_out === 1'b0, "ready while off");
        apb(1'b0, 8'h14, 32'h0, v, err);
        chk(err === 1'b1 && v === 32'h0, "unmapped read");
    endtask : t_reset

    task automatic t_off;
        int len;
        logic rs;
        cfg(1'b0, POL_RISING, MODE_PROG, 2'h0);
        wr(OFS_CAPTURE, 32'h2);
        fire(2'h0, 16'd30, 1'b1);
        expo(300, len, rs);
        chk(len == -1, "exposure while trigger off");
        settle();
    endtask : t_off

    task automatic t_prog;
        int len;
        logic rs;
        wr(OFS_SHUTTER, 32'd40);
        wr(OFS_READOUT, 32'd60);
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 4; s++) begin
                cfg(1'b1, p[0], MODE_PROG, s[1:0]);
                fire(s[1:0] + 2'h1, 16'd30, 1'b1);
                expo(300, len, rs);
                chk(len == -1, "unselected port started exposure");
                settle();
                fire(s[1:0], 16'd80, 1'b0);
                expo(300, len, rs);
                chk(len == 40, "programmable exposure length");
                chk(rs === 1'b1, "readout start after exposure");
                settle();
            end
        end
    endtask : t_prog

    task automatic t_level;
        int len;
        logic rs;
        for (int p = 0; p < 2; p++) begin
            cfg(1'b1, p[0], MODE_LEVEL, 2'h0);
            fire(2'h0, 16'd25, 1'b0);
            expo(300, len, rs);
            chk(len == 40, "short pulse uses shutter minimum");
            settle();
            fire(2'h0, 16'd100, 1'b0);
            expo(300, len, rs);
            chk(len >= 98 && len <= 102, "level exposure follows pulse");
            settle();
        end
    endtask : t_level

    task automatic t_ready;
        int n, len;
        logic rs;
        cfg(1'b1, POL_RISING, MODE_PROG, 2'h0);
        wr(OFS_SHUTTER, 32'd200);
        fire(2'h0, 16'd30, 1'b0);
        n = 0;
        while (exposure_active !== 1'b1 && n < 200) begin
            @(negedge pclk);
            n++;
        end
        chk(exposure_ready_out === 1'b0, "ready low at start");
        @(posedge pclk);
        while (sbusy !== 1'b0 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        fire(2'h0, 16'd30, 1'b1);
        expo(300, len, rs);
        expo(250, len, rs);
        chk(len == -1, "edge while not ready accepted");
        settle();
        chk(exposure_ready_out === 1'b1, "ready back when idle");
        wr(OFS_SHUTTER, 32'd40);
    endtask : t_ready

    task automatic t_overlap;
        logic [31:0] c0, c1;
        int n, len;
        logic rs;
        rd(OFS_STATUS, c0);
        fire(2'h0, 16'd30, 1'b0);
        expo(300, len, rs);
        fire(2'h0, 16'd30, 1'b0);
        n = 0;
        while (exposure_active !== 1'b1 && n < 300) begin
            @(negedge pclk);
            n++;
        end
        chk(exposure_active === 1'b1 && readout_busy === 1'b1, "no overlap");
        @(posedge pclk);
        settle();
        rd(OFS_STATUS, c1);
        chk(c1[31:16] - c0[31:16] === 16'h0002, "frame count per trigger");
    endtask : t_overlap

    task automatic t_single;
        logic [31:0] v;
        int len;
        logic rs;
        wr(OFS_CAPTURE, 32'h0);
        fire(2'h0, 16'd30, 1'b1);
        expo(300, len, rs);
        chk(len == -1, "exposure while unarmed");
        settle();
        wr(OFS_CAPTURE, 32'h1);
        rd(OFS_CAPTURE, v);
        chk(v[CAP_SINGLE_BIT] === 1'b1, "single armed");
        fire(2'h0, 16'd30, 1'b0);
        expo(300, len, rs);
        chk(len == 40, "single exposure");
        settle();
        rd(OFS_CAPTURE, v);
        chk(v[CAP_SINGLE_BIT] === 1'b0, "single not cleared");
        fire(2'h0, 16'd30, 1'b1);
        expo(300, len, rs);
        chk(len == -1, "second single exposure");
        settle();
    endtask : t_single

    // ==========================================================
    // main sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_off();
        t_prog();
        t_level();
        t_ready();
        t_overlap();
        t_single();
        summarize();
    end
endmodule : external_trigger_exposure_ctrl_tb_top
